/* hw/stepper_alarm_pkg.sv */
// Constants for the stepper drive fault display and switch configuration
package stepper_alarm_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OVERLOAD_S = 5;
  localparam int unsigned OVERLOAD_CYC = OVERLOAD_S * CLK_HZ;
  localparam int unsigned POS_DONE_MS = 2;
  localparam int unsigned POS_DONE_CYC = POS_DONE_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned PAUSE_MS = 1500;
  localparam int unsigned PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_US = 10;
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);

  // Speed limit for non-geared motors, r/min
  localparam logic [13:0] OVERSPEED_RPM = 14'h1388;

  // Resolutions, steps per revolution
  localparam int unsigned RES_WIDTH = 14;
  localparam logic [13:0] RES_1000_X1 = 14'h03E8;
  localparam logic [13:0] RES_1000_X10 = 14'h2710;
  localparam logic [13:0] RES_500_X1 = 14'h01F4;
  localparam logic [13:0] RES_500_X10 = 14'h1388;

  // Blink counts of each fault except the system fault, which lights the lamp solid
  localparam logic [3:0] BLINK_OVERLOAD = 4'h2;
  localparam logic [3:0] BLINK_OVERVOLT = 4'h3;
  localparam logic [3:0] BLINK_SPEED_ERR = 4'h4;
  localparam logic [3:0] BLINK_OVERCURRENT = 4'h5;
  localparam logic [3:0] BLINK_OVERSPEED = 4'h6;
  localparam logic [3:0] BLINK_NVM = 4'h7;
  localparam logic [3:0] BLINK_SENSOR = 4'h8;
  localparam logic [3:0] BLINK_NONE = 4'h0;

  // Fault vector bit positions
  localparam int unsigned F_OVERLOAD = 0;
  localparam int unsigned F_OVERVOLT = 1;
  localparam int unsigned F_SPEED_ERR = 2;
  localparam int unsigned F_OVERCURRENT = 3;
  localparam int unsigned F_OVERSPEED = 4;
  localparam int unsigned F_NVM = 5;
  localparam int unsigned F_SENSOR = 6;
  localparam int unsigned F_SYSTEM = 7;
  localparam int unsigned NUM_FAULTS = 8;

  // Faults that survive a clear pulse and need a power cycle
  localparam logic [7:0] STICKY_MASK = 8'hA8;

  typedef enum logic [1:0] {
    BL_IDLE = 2'b00,
    BL_ON = 2'b01,
    BL_OFF = 2'b10,
    BL_PAUSE = 2'b11
  } blink_state_t;

endpackage : stepper_alarm_pkg

/* hw/stepper_drive_alarm_config.sv */
// Fault indication, command decode and power-up switch capture of the drive
`timescale 1ns/10ps

module stepper_drive_alarm_config
  import stepper_alarm_pkg::*;
#(
  parameter int unsigned GEAR_RATIO_X10 = 0,
  parameter int unsigned OVERLOAD_CYCLES = OVERLOAD_CYC,
  parameter int unsigned POS_DONE_CYCLES = POS_DONE_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned PAUSE_CYCLES = PAUSE_CYC,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Front-panel switches
  input wire logic res_base_1000_i,
  input wire logic res_mult_x10_i,
  input wire logic pulse_mode_1p_i,
  input wire logic [3:0] run_current_setting_i,
  input wire logic [3:0] velocity_smoothing_setting_i,
  // Host command pins, high while the optocoupler conducts
  input wire logic cw_pulse_i,
  input wire logic ccw_pulse_i,
  input wire logic resolution_boost_in_i,
  input wire logic fault_clear_in_i,
  // Status from the control core
  input wire logic overload_i,
  input wire logic overvoltage_i,
  input wire logic track_error_i,
  input wire logic overcurrent_i,
  input wire logic [13:0] shaft_speed_rpm_i,
  input wire logic nvm_fault_i,
  input wire logic motor_cable_present_i,
  input wire logic system_fatal_i,
  input wire logic in_position_window_i,
  // Commands to the control core
  output logic step_pulse_o,
  output logic step_dir_cw_o,
  output logic [13:0] steps_per_rev_o,
  output logic [13:0] shaft_steps_per_rev_o,
  output logic [3:0] current_scale_o,
  output logic [3:0] smoothing_level_o,
  output logic config_valid_o,
  // Indicators and status
  output logic power_indicator_o,
  output logic fault_indicator_o,
  output logic fault_active_o,
  output logic [7:0] fault_flags_o,
  output logic position_done_out_o
);

  if (GEAR_RATIO_X10 != 0 && GEAR_RATIO_X10 < 10) begin : g_bad_gear
    $error("gear ratio below 1.0 is not supported");
  end
  if (BLINK_CYCLES == 0 || PAUSE_CYCLES == 0 || POS_DONE_CYCLES == 0) begin : g_bad_t
    $error("timing counts must be at least one cycle");
  end

  // Output-shaft resolution, scaled by the gear ratio fixed at elaboration
  function automatic logic [13:0] shaft_res(input logic [13:0] motor_res);
    shaft_res = (GEAR_RATIO_X10 == 0) ? motor_res :
      14'((int'(motor_res) * 10) / GEAR_RATIO_X10);
  endfunction : shaft_res

  // Three-stage synchronisers; a change counts when stages two and three agree
  localparam int unsigned NSYNC = 13;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  logic [NSYNC-1:0] pin_r;
  assign pin_raw = {velocity_smoothing_setting_i, run_current_setting_i,
                    fault_clear_in_i, resolution_boost_in_i,
                    ccw_pulse_i, cw_pulse_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_filt
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_r[gi] <= 1'b0;
        end else if (sync2_r[gi] == sync3_r[gi]) begin
          pin_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  logic cw_s, ccw_s, boost_s, clear_s;
  logic cw_d_r, ccw_d_r, clear_d_r;
  assign cw_s = pin_r[0];
  assign ccw_s = pin_r[1];
  assign boost_s = pin_r[2];
  assign clear_s = pin_r[3];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cw_d_r <= 1'b0;
      ccw_d_r <= 1'b0;
      clear_d_r <= 1'b0;
    end else begin
      cw_d_r <= cw_s;
      ccw_d_r <= ccw_s;
      clear_d_r <= clear_s;
    end
  end

  logic cw_rise, ccw_rise, clear_pulse;
  assign cw_rise = cw_s & ~cw_d_r;
  assign ccw_rise = ccw_s & ~ccw_d_r;
  assign clear_pulse = clear_s & ~clear_d_r;

  // Power-up capture of the mode and resolution switches. The settle delay
  // lets the synchronisers fill; later switch moves are not seen.
  logic [31:0] settle_cnt_r;
  logic cfg_done_r;
  logic base_1000_r;
  logic mult_x10_r;
  logic mode_1p_r;
  logic sensor_at_boot;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_cnt_r <= '0;
      cfg_done_r <= 1'b0;
    end else if (!cfg_done_r) begin
      if (settle_cnt_r >= SETTLE_CYCLES) begin
        cfg_done_r <= 1'b1;
      end else begin
        settle_cnt_r <= settle_cnt_r + 32'd1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      base_1000_r <= 1'b1;
      mult_x10_r <= 1'b0;
      mode_1p_r <= 1'b0;
    end else if (!cfg_done_r && settle_cnt_r >= SETTLE_CYCLES) begin
      base_1000_r <= res_base_1000_i;
      mult_x10_r <= res_mult_x10_i;
      mode_1p_r <= pulse_mode_1p_i;
    end
  end
  assign sensor_at_boot = !cfg_done_r && settle_cnt_r >= SETTLE_CYCLES &&
                          !motor_cable_present_i;

  // Resolution; the x10 switch or the boost input selects x10
  logic eff_x10;
  logic [13:0] res_nxt;
  assign eff_x10 = mult_x10_r | boost_s;
  always_comb begin
    case ({base_1000_r, eff_x10})
      2'b10: res_nxt = RES_1000_X1;
      2'b11: res_nxt = RES_1000_X10;
      2'b00: res_nxt = RES_500_X1;
      default: res_nxt = RES_500_X10;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      steps_per_rev_o <= RES_1000_X1;
      shaft_steps_per_rev_o <= shaft_res(RES_1000_X1);
      config_valid_o <= 1'b0;
    end else begin
      steps_per_rev_o <= res_nxt;
      shaft_steps_per_rev_o <= shaft_res(res_nxt);
      config_valid_o <= cfg_done_r;
    end
  end

  // Current and smoothing switches pass to the core once stable
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      current_scale_o <= 4'h0;
      smoothing_level_o <= 4'h0;
    end else begin
      current_scale_o <= pin_r[7:4];
      smoothing_level_o <= pin_r[11:8];
    end
  end

  // Fault detection and latching
  logic [31:0] ovl_cnt_r;
  logic ovl_trip;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ovl_cnt_r <= '0;
    end else if (!overload_i) begin
      ovl_cnt_r <= '0;
    end else if (ovl_cnt_r <= OVERLOAD_CYCLES) begin
      ovl_cnt_r <= ovl_cnt_r + 32'd1;
    end
  end
  assign ovl_trip = overload_i && ovl_cnt_r >= OVERLOAD_CYCLES;

  logic [NUM_FAULTS-1:0] fault_set;
  logic [NUM_FAULTS-1:0] fault_r;
  always_comb begin
    fault_set = '0;
    fault_set[F_OVERLOAD] = ovl_trip;
    fault_set[F_OVERVOLT] = overvoltage_i;
    fault_set[F_SPEED_ERR] = track_error_i;
    fault_set[F_OVERCURRENT] = overcurrent_i;
    fault_set[F_OVERSPEED] = (GEAR_RATIO_X10 == 0) &&
                             (shaft_speed_rpm_i > OVERSPEED_RPM);
    fault_set[F_NVM] = nvm_fault_i;
    fault_set[F_SENSOR] = sensor_at_boot;
    fault_set[F_SYSTEM] = system_fatal_i;
  end

  // A fault arriving with the clear pulse stays set
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_r <= '0;
    end else if (clear_pulse) begin
      fault_r <= (fault_r & STICKY_MASK) | fault_set;
    end else begin
      fault_r <= fault_r | fault_set;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_active_o <= 1'b0;
      fault_flags_o <= '0;
    end else begin
      fault_active_o <= |fault_r;
      fault_flags_o <= fault_r;
    end
  end

  // Lowest code wins when several faults are latched
  function automatic logic [3:0] blink_code(input logic [7:0] f);
    if (f[F_OVERLOAD]) blink_code = BLINK_OVERLOAD;
    else if (f[F_OVERVOLT]) blink_code = BLINK_OVERVOLT;
    else if (f[F_SPEED_ERR]) blink_code = BLINK_SPEED_ERR;
    else if (f[F_OVERCURRENT]) blink_code = BLINK_OVERCURRENT;
    else if (f[F_OVERSPEED]) blink_code = BLINK_OVERSPEED;
    else if (f[F_NVM]) blink_code = BLINK_NVM;
    else if (f[F_SENSOR]) blink_code = BLINK_SENSOR;
    else blink_code = BLINK_NONE;
  endfunction : blink_code

  // Blink sequencer
  blink_state_t bl_state_r;
  logic [31:0] bl_cnt_r;
  logic [3:0] bl_left_r;
  logic [3:0] cur_code;
  assign cur_code = blink_code(fault_r);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bl_state_r <= BL_IDLE;
      bl_cnt_r <= '0;
      bl_left_r <= 4'h0;
    end else if (fault_r[F_SYSTEM] || cur_code == BLINK_NONE) begin
      bl_state_r <= BL_IDLE;
      bl_cnt_r <= '0;
    end else begin
      case (bl_state_r)
        BL_IDLE: begin
          bl_state_r <= BL_ON;
          bl_cnt_r <= '0;
          bl_left_r <= cur_code;
        end
        BL_ON: begin
          if (bl_cnt_r >= BLINK_CYCLES - 1) begin
            bl_cnt_r <= '0;
            bl_left_r <= bl_left_r - 4'h1;
            bl_state_r <= (bl_left_r == 4'h1) ? BL_PAUSE : BL_OFF;
          end else begin
            bl_cnt_r <= bl_cnt_r + 32'd1;
          end
        end
        BL_OFF: begin
          if (bl_cnt_r >= BLINK_CYCLES - 1) begin
            bl_cnt_r <= '0;
            bl_state_r <= BL_ON;
          end else begin
            bl_cnt_r <= bl_cnt_r + 32'd1;
          end
        end
        BL_PAUSE: begin
          if (bl_cnt_r >= PAUSE_CYCLES - 1) begin
            bl_cnt_r <= '0;
            bl_left_r <= cur_code;
            bl_state_r <= BL_ON;
          end else begin
            bl_cnt_r <= bl_cnt_r + 32'd1;
          end
        end
        default: begin
          bl_state_r <= BL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_indicator_o <= 1'b0;
      power_indicator_o <= 1'b1;
    end else begin
      power_indicator_o <= 1'b1;
      fault_indicator_o <= fault_r[F_SYSTEM] || bl_state_r == BL_ON;
    end
  end

  // Step decode; commands are dropped while any fault stands, as the motor
  // is unexcited then and counting steps would corrupt the position
  logic step_nxt;
  logic dir_nxt;
  always_comb begin
    step_nxt = 1'b0;
    dir_nxt = step_dir_cw_o;
    if (mode_1p_r) begin
      step_nxt = cw_rise;
      dir_nxt = ccw_s;
    end else if (cw_rise && !ccw_rise) begin
      step_nxt = 1'b1;
      dir_nxt = 1'b1;
    end else if (ccw_rise && !cw_rise) begin
      step_nxt = 1'b1;
      dir_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      step_pulse_o <= 1'b0;
      step_dir_cw_o <= 1'b1;
    end else begin
      step_pulse_o <= step_nxt && cfg_done_r && !(|fault_r);
      step_dir_cw_o <= dir_nxt;
    end
  end

  // Position-done timer restarts on every accepted step
  logic [31:0] idle_cnt_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt_r <= '0;
      position_done_out_o <= 1'b0;
    end else if (step_pulse_o) begin
      idle_cnt_r <= '0;
      position_done_out_o <= 1'b0;
    end else begin
      if (idle_cnt_r < POS_DONE_CYCLES) begin
        idle_cnt_r <= idle_cnt_r + 32'd1;
      end
      position_done_out_o <= (idle_cnt_r >= POS_DONE_CYCLES) &&
                             in_position_window_i;
    end
  end

endmodule : stepper_drive_alarm_config

/* tb/host_ctrl_model.sv */
// Host motion controller issuing step pulses on the command lines
`timescale 1ns/10ps
module host_ctrl_model (
  // Clock
  input wire logic mclk_i,
  // Bench request
  input wire logic req_i,
  input wire logic mode_1p_i,
  input wire logic dir_cw_i,
  input wire logic [3:0] count_i,
  input wire logic [3:0] width_i,
  // Pins, high while the optocoupler conducts
  output logic cw_pulse_o,
  output logic ccw_pulse_o,
  output logic busy_o
);
  logic [3:0] left_r = 4'h0;
  logic [3:0] tick_r = 4'h0;
  logic pin_r = 1'h0;

  // Each level lasts width_i cycles; the drive needs two at least
  always @(posedge mclk_i) begin
    if (left_r == 4'h0) begin
      left_r <= req_i ? count_i : 4'h0;
      tick_r <= width_i;
    end else if (tick_r != 4'h1) begin
      tick_r <= tick_r - 4'h1;
    end else begin
      tick_r <= width_i;
      pin_r <= ~pin_r;
      left_r <= left_r - {3'h0, pin_r};
    end
  end
  assign busy_o = left_r != 4'h0;
  assign cw_pulse_o = pin_r && (mode_1p_i || dir_cw_i);
  // Direction is a steady level in one-pulse mode
  assign ccw_pulse_o = mode_1p_i ? dir_cw_i : pin_r && !dir_cw_i;
endmodule : host_ctrl_model

/* tb/stepper_alarm_assertions.sv */
// Concurrent checks on the drive fault and command ports
`timescale 1ns/10ps
module stepper_alarm_assertions
  import stepper_alarm_pkg::*;
#(
  parameter int unsigned GEAR_RATIO_X10 = 0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Inputs
  input wire logic pulse_mode_1p_i,
  input wire logic cw_pulse_i,
  input wire logic ccw_pulse_i,
  input wire logic overvoltage_i,
  input wire logic track_error_i,
  input wire logic [13:0] shaft_speed_rpm_i,
  // Outputs
  input wire logic step_pulse_o,
  input wire logic step_dir_cw_o,
  input wire logic config_valid_o,
  input wire logic power_indicator_o,
  input wire logic fault_indicator_o,
  input wire logic fault_active_o,
  input wire logic [7:0] fault_flags_o,
  input wire logic position_done_out_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // A step is only owed in two-pulse mode with no fault latched
  sequence ready_2p;
    !pulse_mode_1p_i && config_valid_o && !fault_active_o;
  endsequence
  sequence cw_rise;
    $rose(cw_pulse_i) && !ccw_pulse_i;
  endsequence
  sequence ccw_rise;
    $rose(ccw_pulse_i) && !cw_pulse_i;
  endsequence

  power_lamp_a: assert property (power_indicator_o)
    else $error("power lamp dark");
  overvolt_latch_a: assert property (overvoltage_i |->
    ##[1:2] fault_flags_o[F_OVERVOLT]) else $error("overvolt missed");
  track_latch_a: assert property (track_error_i |->
    ##[1:2] fault_flags_o[F_SPEED_ERR]) else $error("speed err missed");
  overspeed_latch_a: assert property (
    GEAR_RATIO_X10 == 0 && shaft_speed_rpm_i > OVERSPEED_RPM |->
    ##[1:2] fault_flags_o[F_OVERSPEED]) else $error("overspeed missed");
  sticky_hold_a: assert property (
    (fault_flags_o & $past(fault_flags_o) & STICKY_MASK) ==
    ($past(fault_flags_o) & STICKY_MASK)) else $error("sticky lost");
  system_solid_a: assert property (
    fault_flags_o[F_SYSTEM] [*4] |-> fault_indicator_o)
    else $error("system lamp not solid");
  cw_step_a: assert property (ready_2p ##0 cw_rise |->
    ##[4:7] step_pulse_o ##1 step_dir_cw_o) else $error("no cw step");
  ccw_step_a: assert property (ready_2p ##0 ccw_rise |->
    ##[4:7] step_pulse_o ##1 !step_dir_cw_o) else $error("no ccw step");
  done_drop_a: assert property (step_pulse_o |->
    ##2 !position_done_out_o [*6]) else $error("done while moving");
endmodule : stepper_alarm_assertions

bind stepper_drive_alarm_config stepper_alarm_assertions #(
  .GEAR_RATIO_X10(GEAR_RATIO_X10)
) u_sva (
  .mclk_i(mclk_i), .rst_i(rst_i), .pulse_mode_1p_i(pulse_mode_1p_i),
  .cw_pulse_i(cw_pulse_i), .ccw_pulse_i(ccw_pulse_i),
  .overvoltage_i(overvoltage_i), .track_error_i(track_error_i),
  .shaft_speed_rpm_i(shaft_speed_rpm_i), .step_pulse_o(step_pulse_o),
  .step_dir_cw_o(step_dir_cw_o), .config_valid_o(config_valid_o),
  .power_indicator_o(power_indicator_o),
  .fault_indicator_o(fault_indicator_o), .fault_active_o(fault_active_o),
  .fault_flags_o(fault_flags_o), .position_done_out_o(position_done_out_o)
);

/* tb/testbench.sv */
// Self-checking bench for fault display, decode and switch capture
`timescale 1ns/10ps
module testbench;
  import stepper_alarm_pkg::*;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic base = 1'h1, x10 = 1'h0, p1 = 1'h0, boost = 1'h0, clr = 1'h0;
  logic ovl = 1'h0, ovv = 1'h0, trk = 1'h0, nvm = 1'h0, sys = 1'h0;
  logic cab = 1'h1, win = 1'h0, req = 1'h0, dcmd = 1'h1, oc = 1'h0;
  logic [3:0] cur = 4'h0, smo = 4'h0, cnt = 4'h0, wid = 4'h2;
  logic [13:0] rpm = 14'h0000;
  logic cw, ccw, busy, stp, dcw, cv, pwr, ind, fact, pdone;
  logic [13:0] spr, sspr;
  logic [3:0] csc, sml;
  logic [7:0] flags;
  int fail_count = 0;
  int compares = 0;
  int steps = 0;
  int s0 = 0;
  int fbit[5] = '{F_OVERLOAD, F_OVERVOLT, F_SPEED_ERR, F_OVERSPEED, F_NVM};
  logic [3:0] fcode[5] = '{BLINK_OVERLOAD, BLINK_OVERVOLT,
    BLINK_SPEED_ERR, BLINK_OVERSPEED, BLINK_NVM};
  logic [13:0] rexp[4] = '{RES_500_X1, RES_500_X10, RES_1000_X1,
    RES_1000_X10};

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // Short counts keep blink groups and timers within a brief run
  stepper_drive_alarm_config #(
    .OVERLOAD_CYCLES(20), .POS_DONE_CYCLES(10), .BLINK_CYCLES(4),
    .PAUSE_CYCLES(12), .SETTLE_CYCLES(4)
  ) uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .res_base_1000_i(base),
    .res_mult_x10_i(x10), .pulse_mode_1p_i(p1),
    .run_current_setting_i(cur), .velocity_smoothing_setting_i(smo),
    .cw_pulse_i(cw), .ccw_pulse_i(ccw), .resolution_boost_in_i(boost),
    .fault_clear_in_i(clr), .overload_i(ovl), .overvoltage_i(ovv),
    .track_error_i(trk), .overcurrent_i(oc), .shaft_speed_rpm_i(rpm),
    .nvm_fault_i(nvm), .motor_cable_present_i(cab), .system_fatal_i(sys),
    .in_position_window_i(win), .step_pulse_o(stp), .step_dir_cw_o(dcw),
    .steps_per_rev_o(spr), .shaft_steps_per_rev_o(sspr),
    .current_scale_o(csc), .smoothing_level_o(sml), .config_valid_o(cv),
    .power_indicator_o(pwr), .fault_indicator_o(ind),
    .fault_active_o(fact), .fault_flags_o(flags),
    .position_done_out_o(pdone)
  );

  host_ctrl_model u_host (
    .mclk_i(mclk_i), .req_i(req), .mode_1p_i(p1), .dir_cw_i(dcmd),
    .count_i(cnt), .width_i(wid), .cw_pulse_o(cw), .ccw_pulse_o(ccw),
    .busy_o(busy)
  );

  always @(posedge mclk_i) begin
    if (stp === 1'h1) begin
      steps <= steps + 1;
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask : cyc

  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic bail();
    fail_count++;
    print_verdict();
  endtask : bail

  // The resolution and pulse-mode switches only move while the drive is held in reset
  task automatic power_up(input logic b, input logic x, input logic m);
    int n;
    rst_i = 1'h1;
    base = b;
    x10 = x;
    p1 = m;
    cyc(12);
    check(14'(pwr), 14'h0001);
    rst_i = 1'h0;
    n = 0;
    while (cv !== 1'h1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (cv !== 1'h1) bail();
  endtask : power_up

  task automatic send(input logic d, input logic [3:0] k,
                      input logic [3:0] w);
    int n;
    s0 = steps;
    dcmd = d;
    cnt = k;
    wid = w;
    req = 1'h1;
    cyc(2);
    req = 1'h0;
    n = 0;
    while (busy !== 1'h0 && n < 200) begin
      cyc(1);
      n++;
    end
    if (busy !== 1'h0) bail();
    cyc(10);
  endtask : send

  // One whole period holds exactly one group of rises
  task automatic blinks(input logic [3:0] code);
    int r;
    logic p;
    r = 0;
    p = ind;
    repeat (int'(code) * 8 + 8) begin
      cyc(1);
      if (ind === 1'h1 && p === 1'h0) r++;
      p = ind;
    end
    check(14'(r), 14'(code));
  endtask : blinks

  task automatic clear_pulse();
    clr = 1'h1;
    cyc(4);
    clr = 1'h0;
    cyc(6);
  endtask : clear_pulse

  initial begin
    for (int i = 0; i < 4; i++) begin
      boost = i[0];
      power_up(i[1], i[0], 1'h0);
      cyc(8);
      check(spr, rexp[i]);
      check(sspr, rexp[i]);
    end
    power_up(1'h1, 1'h0, 1'h0);
    boost = 1'h1;
    cur = 4'h9;
    smo = 4'hF;
    cyc(8);
    check(spr, RES_1000_X10);
    check(14'(csc), 14'h0009);
    check(14'(sml), 14'h000F);
    boost = 1'h0;
    send(1'h1, 4'h3, 4'h2);
    check(14'(steps - s0), 14'h0003);
    check(14'(dcw), 14'h0001);
    win = 1'h1;
    send(1'h0, 4'h2, 4'h5);
    check(14'(steps - s0), 14'h0002);
    check(14'(dcw), 14'h0000);
    cyc(4);
    check(14'(pdone), 14'h0001);
    power_up(1'h1, 1'h0, 1'h1);
    send(1'h1, 4'h2, 4'h2);
    check(14'(steps - s0), 14'h0002);
    check(14'(dcw), 14'h0001);
    send(1'h0, 4'h2, 4'h3);
    check(14'(steps - s0), 14'h0002);
    check(14'(dcw), 14'h0000);
    ovl = 1'h1;
    rpm = OVERSPEED_RPM;
    cyc(10);
    ovl = 1'h0;
    cyc(4);
    check(14'(flags), 14'h0000);
    for (int i = 0; i < 5; i++) begin
      ovl = (i == 0);
      ovv = (i == 1);
      trk = (i == 2);
      rpm = (i == 3) ? 14'h1389 : 14'h0000;
      nvm = (i == 4);
      cyc(30);
      {ovl, ovv, trk, nvm} = 4'h0;
      rpm = 14'h0000;
      cyc(4);
      check(14'(flags), 14'h0001 << fbit[i]);
      blinks(fcode[i]);
      clear_pulse();
      check(14'(flags), (i == 4) ? 14'h0020 : 14'h0000);
    end
    // Overcurrent needs a power cycle, like the memory fault left latched
    oc = 1'h1;
    cyc(2);
    oc = 1'h0;
    cyc(4);
    check(14'(flags), 14'h0028);
    clear_pulse();
    check(14'(flags), 14'h0028);
    cab = 1'h0;
    power_up(1'h1, 1'h0, 1'h0);
    cab = 1'h1;
    cyc(4);
    check(14'(flags), 14'h0040);
    blinks(BLINK_SENSOR);
    power_up(1'h1, 1'h0, 1'h0);
    sys = 1'h1;
    cyc(1);
    sys = 1'h0;
    cyc(6);
    blinks(BLINK_NONE);
    check(14'(ind), 14'h0001);
    clear_pulse();
    check(14'(flags), 14'h0080);
    print_verdict();
  end
endmodule : testbench
